//--- hw/brake_seq_consts.svh
// offsets, field positions, reset values and timing counts of the brake sequencer
`ifndef BRAKE_SEQ_CONSTS_SVH
`define BRAKE_SEQ_CONSTS_SVH

`define OFF_SRV_SPEC    8'h00
`define OFF_SPN_SPEC    8'h04
`define OFF_SRV_FUNC5   8'h08
`define OFF_SPD_LIMIT   8'h0C
`define OFF_DECEL_MS    8'h10
`define OFF_STATUS      8'h14

`define FAST_SEQ_BIT    2
`define OUT2_SEL_LSB    8
`define OUT2_SEL_OFF    2'b00
`define OUT2_SEL_SPEED  2'b01

`define RST_SPEC        16'h0000
`define RST_FUNC5       16'h0000
`define RST_SPD_LIMIT   16'h0000
`define RST_DECEL_MS    16'h0000

`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10

`define T_CLK_NS        8
`define T_MS_NS         1000000
`define MS_CYCLES       (`T_MS_NS / `T_CLK_NS)
`define READY_EXT_DB_MS 16'h000A
`define NORMAL_SETTLE_MS 16'h0014
`define BRAKE_LAG_MS    16'h0005

`endif

//--- hw/brake_seq_pkg.sv
// types of the brake sequencer
package brake_seq_pkg;

  typedef enum logic [2:0] {
    ST_OFF    = 3'b000,
    ST_CHARGE = 3'b001,
    ST_SETTLE = 3'b010,
    ST_ON     = 3'b011,
    ST_DECEL  = 3'b100,
    ST_LAG    = 3'b101
  } seq_state_t;

  typedef struct packed {
    seq_state_t  state;
    logic [15:0] cnt;
    logic [23:0] div;
    logic        motor_on;
    logic        brake_rel;
    logic        dyn_brake;
    logic        gen1;
    logic        gen2;
    logic        gen3;
    logic        ready;
    logic        contactor;
    logic [15:0] srv_spec;
    logic [15:0] spn_spec;
    logic [15:0] func5;
    logic [15:0] spd_lim;
    logic [15:0] decel;
    logic        awready;
    logic        wready;
    logic        aw_hold;
    logic [7:0]  aw_addr;
    logic        w_hold;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } seq_regs_t;

endpackage

//--- hw/motor_brake_sequencer.sv
// motor brake and ready-on sequencer with AXI4-Lite registers
//
// Added by the designer: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "brake_seq_consts.svh"

module motor_brake_sequencer #(
  parameter int unsigned NUM_AXES      = 2,
  parameter int unsigned SPD_W         = 16,
  parameter int unsigned MS_CYCLES     = `MS_CYCLES,
  parameter logic        EXT_DYN_BRAKE = 1'b1
) (
  input  wire logic                      clk_sys_i,
  input  wire logic                      rst_i,
  input  wire logic                      servo_on_i,
  input  wire logic                      estop_i,
  input  wire logic                      power_ready_i,
  input  wire logic [NUM_AXES*SPD_W-1:0] axis_speed_i,
  output var  logic                      motor_on_o,
  output var  logic                      brake_release_o,
  output var  logic                      dyn_brake_o,
  output var  logic                      general_output_one_o,
  output var  logic                      general_output_two_o,
  output var  logic                      general_output_three_o,
  output var  logic                      ready_o,
  output var  logic                      contactor_o,
  input  wire logic [7:0]                s_axi_awaddr_i,
  input  wire logic                      s_axi_awvalid_i,
  output var  logic                      s_axi_awready_o,
  input  wire logic [31:0]               s_axi_wdata_i,
  input  wire logic [3:0]                s_axi_wstrb_i,
  input  wire logic                      s_axi_wvalid_i,
  output var  logic                      s_axi_wready_o,
  output var  logic [1:0]                s_axi_bresp_o,
  output var  logic                      s_axi_bvalid_o,
  input  wire logic                      s_axi_bready_i,
  input  wire logic [7:0]                s_axi_araddr_i,
  input  wire logic                      s_axi_arvalid_i,
  output var  logic                      s_axi_arready_o,
  output var  logic [31:0]               s_axi_rdata_o,
  output var  logic [1:0]                s_axi_rresp_o,
  output var  logic                      s_axi_rvalid_o,
  input  wire logic                      s_axi_rready_i
);
  import brake_seq_pkg::*;

  seq_regs_t         q;
  seq_regs_t         d;
  logic [NUM_AXES-1:0] spd_ok;
  logic              spd_all;
  logic              fast_seq;
  logic              ms_tick;
  logic              stop_req;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] st);
    logic [15:0] r;
    r = old;
    if (st[0]) begin
      r[7:0] = wd[7:0];
    end
    if (st[1]) begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction

  // per-axis speed check against the shared limit
  genvar g;
  generate
    for (g = 0; g < NUM_AXES; g = g + 1) begin : g_axis
      assign spd_ok[g] = axis_speed_i[g*SPD_W +: SPD_W] < q.spd_lim[SPD_W-1:0];
    end
  endgenerate

  assign spd_all  = &spd_ok;
  // supply follows the fast sequence only when both settings ask for it
  assign fast_seq = q.srv_spec[`FAST_SEQ_BIT] & q.spn_spec[`FAST_SEQ_BIT];
  assign ms_tick  = q.div == 24'(MS_CYCLES - 1);
  assign stop_req = estop_i | ~servo_on_i;

  always_comb begin
    logic [31:0] rd;
    logic [1:0]  rr;
    rd = 32'h0000_0000;
    rr = `RESP_OKAY;
    d  = q;
    d.div = ms_tick ? 24'h00_0000 : q.div + 24'h00_0001;
    if (ms_tick && q.cnt != 16'h0000) begin
      d.cnt = q.cnt - 16'h0001;
    end

    case (q.state)
      ST_OFF: begin
        if (!stop_req) begin
          d.state = ST_CHARGE;
        end
      end
      ST_CHARGE: begin
        if (stop_req) begin
          d.state = ST_OFF;
        end else if (power_ready_i) begin
          d.div = 24'h00_0000;
          if (!fast_seq) begin
            d.state = ST_SETTLE;
            d.cnt   = `NORMAL_SETTLE_MS;
          end else if (EXT_DYN_BRAKE) begin
            d.state = ST_SETTLE;
            d.cnt   = `READY_EXT_DB_MS;
          end else begin
            d.state = ST_ON;
          end
        end
      end
      ST_SETTLE: begin
        if (stop_req) begin
          d.state = ST_OFF;
        end else if (q.cnt == 16'h0000) begin
          d.state = ST_ON;
        end
      end
      ST_ON: begin
        if (estop_i) begin
          // keep torque while the stop delay runs so the axis does not fall
          d.state = ST_DECEL;
          d.cnt   = q.decel;
          d.div   = 24'h00_0000;
        end else if (!servo_on_i) begin
          d.state = ST_OFF;
        end
      end
      ST_DECEL: begin
        if (q.cnt == 16'h0000) begin
          d.state = ST_LAG;
          d.cnt   = `BRAKE_LAG_MS;
          d.div   = 24'h00_0000;
        end
      end
      ST_LAG: begin
        if (q.cnt == 16'h0000) begin
          d.state = ST_OFF;
        end
      end
      default: begin
        d.state = ST_OFF;
      end
    endcase

    d.motor_on  = d.state == ST_ON || d.state == ST_DECEL || d.state == ST_LAG;
    // release needs gate power both now and in the previous cycle
    d.brake_rel = (d.state == ST_ON || d.state == ST_DECEL) && d.motor_on && q.motor_on;
    d.dyn_brake = ~d.brake_rel;
    d.gen1      = d.brake_rel;
    d.gen3      = d.brake_rel;
    d.gen2      = (q.func5[`OUT2_SEL_LSB +: 2] == `OUT2_SEL_SPEED) && spd_all;
    d.ready     = d.state == ST_ON;
    d.contactor = ~estop_i;

    if (s_axi_awvalid_i && q.awready) begin
      d.aw_hold = 1'b1;
      d.aw_addr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && q.wready) begin
      d.w_hold = 1'b1;
      d.wdata  = s_axi_wdata_i;
      d.wstrb  = s_axi_wstrb_i;
    end
    if (q.bvalid && s_axi_bready_i) begin
      d.bvalid = 1'b0;
    end
    if (q.aw_hold && q.w_hold && !q.bvalid) begin
      d.aw_hold = 1'b0;
      d.w_hold  = 1'b0;
      d.bvalid  = 1'b1;
      d.bresp   = `RESP_OKAY;
      case (q.aw_addr)
        `OFF_SRV_SPEC:  d.srv_spec = merge16(q.srv_spec, q.wdata, q.wstrb);
        `OFF_SPN_SPEC:  d.spn_spec = merge16(q.spn_spec, q.wdata, q.wstrb);
        `OFF_SRV_FUNC5: d.func5    = merge16(q.func5, q.wdata, q.wstrb);
        `OFF_SPD_LIMIT: d.spd_lim  = merge16(q.spd_lim, q.wdata, q.wstrb);
        `OFF_DECEL_MS:  d.decel    = merge16(q.decel, q.wdata, q.wstrb);
        `OFF_STATUS:    d.bresp    = `RESP_OKAY;
        default:        d.bresp    = `RESP_SLVERR;
      endcase
    end
    d.awready = ~d.aw_hold;
    d.wready  = ~d.w_hold;

    case (s_axi_araddr_i)
      `OFF_SRV_SPEC:  rd = {16'h0000, q.srv_spec};
      `OFF_SPN_SPEC:  rd = {16'h0000, q.spn_spec};
      `OFF_SRV_FUNC5: rd = {16'h0000, q.func5};
      `OFF_SPD_LIMIT: rd = {16'h0000, q.spd_lim};
      `OFF_DECEL_MS:  rd = {16'h0000, q.decel};
      `OFF_STATUS:    rd = {24'h00_0000, power_ready_i, spd_all, q.ready, q.brake_rel, q.motor_on, q.state};
      default:        rr = `RESP_SLVERR;
    endcase
    if (q.rvalid && s_axi_rready_i) begin
      d.rvalid = 1'b0;
    end
    if (s_axi_arvalid_i && q.arready) begin
      d.rvalid = 1'b1;
      d.rdata  = rd;
      d.rresp  = rr;
    end
    d.arready = ~d.rvalid;
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      q          <= '0;
      q.state    <= ST_OFF;
      q.dyn_brake <= 1'b1;
      q.srv_spec <= `RST_SPEC;
      q.spn_spec <= `RST_SPEC;
      q.func5    <= `RST_FUNC5;
      q.spd_lim  <= `RST_SPD_LIMIT;
      q.decel    <= `RST_DECEL_MS;
    end else begin
      q <= d;
    end
  end

  assign motor_on_o             = q.motor_on;
  assign brake_release_o        = q.brake_rel;
  assign dyn_brake_o            = q.dyn_brake;
  assign general_output_one_o   = q.gen1;
  assign general_output_two_o   = q.gen2;
  assign general_output_three_o = q.gen3;
  assign ready_o                = q.ready;
  assign contactor_o            = q.contactor;
  assign s_axi_awready_o        = q.awready;
  assign s_axi_wready_o         = q.wready;
  assign s_axi_bvalid_o         = q.bvalid;
  assign s_axi_bresp_o          = q.bresp;
  assign s_axi_arready_o        = q.arready;
  assign s_axi_rvalid_o         = q.rvalid;
  assign s_axi_rdata_o          = q.rdata;
  assign s_axi_rresp_o          = q.rresp;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  brake_needs_gate_a: assert property (brake_release_o |-> motor_on_o && $past(motor_on_o))
    else $error("brake released without gate power");
  dyn_brake_tracks_a: assert property ($changed(brake_release_o) |-> $changed(dyn_brake_o))
    else $error("dynamic brake not switched with brake output");
  release_after_gate_a: assert property ($rose(motor_on_o) |-> !brake_release_o ##1 brake_release_o || !ready_o)
    else $error("brake released before gate power");
  seq_normal_a: assert property (q.state == ST_CHARGE && power_ready_i && !stop_req && !fast_seq
    |=> q.state == ST_SETTLE && q.cnt == `NORMAL_SETTLE_MS)
    else $error("normal sequence not chosen");
  fast_ext_db_a: assert property (q.state == ST_CHARGE && power_ready_i && !stop_req && fast_seq && EXT_DYN_BRAKE
    |=> q.state == ST_SETTLE && q.cnt == 16'h000A && !ready_o)
    else $error("ready not delayed for external contactor");
  servo_off_same_a: assert property (q.state == ST_ON && !servo_on_i && !estop_i
    |=> !motor_on_o && !brake_release_o && dyn_brake_o)
    else $error("brake and gate not dropped together");
  estop_hold_a: assert property (q.state == ST_ON && estop_i |=> motor_on_o && q.state == ST_DECEL)
    else $error("no drop prevention on emergency stop");
  decel_end_a: assert property (q.state == ST_DECEL && q.cnt == 16'h0000
    |=> !brake_release_o && motor_on_o ##1 motor_on_o)
    else $error("brake not applied under torque at stop delay end");
  brake_pair_a: assert property (general_output_one_o == brake_release_o && general_output_three_o == brake_release_o)
    else $error("safe brake relay pair disagrees");
  speed_out_a: assert property (##1 general_output_two_o ==
    ($past(q.func5[`OUT2_SEL_LSB +: 2]) == `OUT2_SEL_SPEED && $past(spd_all)))
    else $error("specified speed output wrong");
  speed_off_a: assert property (q.func5[`OUT2_SEL_LSB +: 2] == `OUT2_SEL_OFF |=> !general_output_two_o)
    else $error("disabled output two is driven");
  speed_all_a: assert property (!(&spd_ok) |=> !general_output_two_o)
    else $error("speed output on while an axis is fast");

  reach_ready_c: cover property (q.state == ST_SETTLE ##1 q.state == ST_ON ##1 brake_release_o);
  estop_path_c:  cover property (q.state == ST_DECEL ##1 q.state == ST_LAG);
  speed_on_c:    cover property ($rose(general_output_two_o));
endmodule
`default_nettype wire

//--- verification/nc_ctrl_model.sv
// controller and supply model driving the sequencer command levels
`timescale 1ns/1ps
`default_nettype none
module nc_ctrl_model #(
  parameter int unsigned CHARGE_CYC = 4
) (
  input  wire logic clk_sys_i,
  input  wire logic on_req_i,
  input  wire logic stop_req_i,
  output var  logic servo_on_o,
  output var  logic estop_o,
  output var  logic power_ready_o
);
  int unsigned chg = 0;
  initial begin
    servo_on_o = 1'h0;
    estop_o = 1'h0;
    power_ready_o = 1'h0;
  end
  // supply charges slowly once and stays charged until an emergency stop
  always @(posedge clk_sys_i) begin
    servo_on_o <= on_req_i;
    estop_o <= stop_req_i;
    if (stop_req_i) begin
      chg <= 0;
      power_ready_o <= 1'h0;
    end else if (on_req_i && chg < CHARGE_CYC) begin
      chg <= chg + 1;
    end else if (chg == CHARGE_CYC) begin
      power_ready_o <= 1'h1;
    end
  end
endmodule
`default_nettype wire

//--- verification/motor_brake_sequencer_tb_top.sv
// self-checking bench for the motor brake sequencer
`timescale 1ns/1ps
`default_nettype none
`include "brake_seq_consts.svh"
module motor_brake_sequencer_tb_top;
  logic        clk, rst, on_req, stop_req, servo_on, estop, pwr;
  logic        motor_on, brake, dynb, g1, g2, g3, rdy, ctor;
  logic [31:0] speed, wdata, rdata;
  logic [7:0]  awaddr, araddr;
  logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  int          error_cnt, total_checks;

  nc_ctrl_model nc (.clk_sys_i(clk), .on_req_i(on_req), .stop_req_i(stop_req), .servo_on_o(servo_on),
    .estop_o(estop), .power_ready_o(pwr));
  motor_brake_sequencer #(.MS_CYCLES(10)) dut (.clk_sys_i(clk), .rst_i(rst), .servo_on_i(servo_on),
    .estop_i(estop), .power_ready_i(pwr), .axis_speed_i(speed), .motor_on_o(motor_on), .brake_release_o(brake),
    .dyn_brake_o(dynb), .general_output_one_o(g1), .general_output_two_o(g2), .general_output_three_o(g3),
    .ready_o(rdy), .contactor_o(ctor), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready));

  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end

  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic timeout();
    error_cnt++;
    $display("CHECK FAILED t=%0t wait ran out", $time);
    finish_test();
  endtask

  // handshakes are judged at the falling edge and released after the next rising edge
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    int   n;
    logic aw_h, w_h, b_h;
    n = 0;
    b_h = 1'h0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!b_h) begin
      @(negedge clk);
      aw_h = awvalid & awready;
      w_h = wvalid & wready;
      b_h = bvalid;
      resp = bresp;
      @(posedge clk);
      if (aw_h) awvalid <= 1'h0;
      if (w_h) wvalid <= 1'h0;
      if (b_h) bready <= 1'h0;
      n++;
      if (n > 100) timeout();
    end
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    int   n;
    logic ar_h, r_h;
    n = 0;
    r_h = 1'h0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    while (!r_h) begin
      @(negedge clk);
      ar_h = arvalid & arready;
      r_h = rvalid;
      d = rdata;
      resp = rresp;
      @(posedge clk);
      if (ar_h) arvalid <= 1'h0;
      if (r_h) rready <= 1'h0;
      n++;
      if (n > 100) timeout();
    end
  endtask

  task automatic reg_scn();
    logic [31:0] d;
    for (int i = 0; i < 5; i++) begin
      axi_rd(8'(i * 4), d, r);
      check(d, 32'h0);
    end
    axi_wr(`OFF_SPD_LIMIT, 32'hFFFF_0064, r);
    axi_rd(`OFF_SPD_LIMIT, d, r);
    check(d, 32'h0000_0064);
    axi_wr(8'h18, 32'h1, r);
    check(32'(r), 32'(`RESP_SLVERR));
    axi_rd(8'h18, d, r);
    check({d[29:0], r}, 32'(`RESP_SLVERR));
  endtask

  task automatic spd_scn(input logic [31:0] sel, input logic [31:0] spd, input logic exp);
    axi_wr(`OFF_SRV_FUNC5, sel, r);
    @(posedge clk);
    speed <= spd;
    repeat (4) @(negedge clk);
    check(32'(g2), 32'(exp));
  endtask

  // requests servo on, times the ready-on sequence and checks the brake follows the gate
  task automatic ready_scn(input int lo, input int hi);
    int n;
    n = 0;
    @(posedge clk);
    on_req <= 1'h1;
    @(negedge clk);
    while (rdy !== 1'h1) begin
      n++;
      if (n > 1000) timeout();
      @(negedge clk);
    end
    check(32'(n >= lo && n <= hi), 32'h1);
    check({29'h0, ctor, motor_on, brake}, 32'h6);
    @(negedge clk);
    check({28'h0, brake, dynb, g1, g3}, 32'h0000_000B);
  endtask

  task automatic off_scn();
    int n;
    n = 0;
    @(posedge clk);
    on_req <= 1'h0;
    @(negedge clk);
    while (motor_on === 1'h1) begin
      check(32'(brake), 32'h1);
      n++;
      if (n > 10) timeout();
      @(negedge clk);
    end
    check({29'h0, brake, dynb, rdy}, 32'h2);
  endtask

  task automatic estop_scn();
    logic [31:0] d;
    axi_wr(`OFF_DECEL_MS, 32'h0000_0002, r);
    @(posedge clk);
    stop_req <= 1'h1;
    repeat (12) @(negedge clk);
    check({29'h0, ctor, motor_on, brake}, 32'h3);
    repeat (20) @(negedge clk);
    check({30'h0, motor_on, brake}, 32'h2);
    repeat (60) @(negedge clk);
    check({29'h0, motor_on, brake, dynb}, 32'h1);
    // stopped and uncharged, both axes below the limit
    axi_rd(`OFF_STATUS, d, r);
    check(d, 32'h0000_0040);
    @(posedge clk);
    stop_req <= 1'h0;
    ready_scn(200, 230);
  endtask

  initial begin
    rst = 1'h1;
    {on_req, stop_req, awvalid, wvalid, bready, arvalid, rready} = 7'h0;
    {speed, wdata, awaddr, araddr} = 80'h0;
    wstrb = 4'hF;
    error_cnt = 0;
    total_checks = 0;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    repeat (3) @(posedge clk);
    reg_scn();
    spd_scn(32'h0000_0100, {16'h0032, 16'h0032}, 1'h1);
    spd_scn(32'h0000_0100, {16'h0032, 16'h0096}, 1'h0);
    spd_scn(32'h0000_0100, {16'h0064, 16'h0032}, 1'h0);
    spd_scn(32'h0000_0000, {16'h0032, 16'h0032}, 1'h0);
    axi_wr(`OFF_SRV_SPEC, 32'h0000_0004, r);
    axi_wr(`OFF_SPN_SPEC, 32'h0000_0004, r);
    ready_scn(100, 120);
    off_scn();
    axi_wr(`OFF_SPN_SPEC, 32'h0, r);
    ready_scn(200, 220);
    repeat (2) @(posedge clk);
    estop_scn();
    off_scn();
    finish_test();
  end
endmodule
`default_nettype wire
